// ### verilog/vcm_pkg.sv
// Shared constants and types for the configuration-code multiplexer
`default_nettype none

package vcm_pkg;

    // Bus addresses chosen by the address strap
    localparam logic [6:0] ADDR_STRAP_HI = 7'h4e;
    localparam logic [6:0] ADDR_STRAP_LO = 7'h37;

    // Register indices on the serial port
    localparam logic [1:0] REG_CODE_A = 2'h0;
    localparam logic [1:0] REG_CODE_B = 2'h1;
    localparam logic [1:0] REG_SNAPSHOT = 2'h2;

    // Path code values, held in bits 7 and 6
    localparam logic [1:0] PATH_CODE_A = 2'h0;
    localparam logic [1:0] PATH_CODE_B = 2'h1;
    localparam logic [1:0] PATH_INPUT = 2'h2;
    localparam logic [1:0] PATH_RESET = 2'h0;
    localparam int PATH_CODE_HI_POS = 7;
    localparam int PATH_CODE_LO_POS = 6;

    // Reset contents of the stored codes and the snapshot pad bits
    localparam logic [5:0] CODE_RESET = 6'h00;
    localparam logic [2:0] SNAP_PAD = 3'h0;

    // Serial framing
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] BYTE_DONE = 4'h8;

    // Non-volatile update time
    localparam int CLK_HZ = 25_000_000;
    localparam int NV_UPDATE_MS = 10;
    localparam int NV_UPDATE_CYCLES = NV_UPDATE_MS * (CLK_HZ / 1000);
    localparam int NV_CNT_W = 18;

    // Stored code layout, bits 5 to 0 of a code register
    typedef struct packed {
        logic out_hi;
        logic aux_bit;
        logic [3:0] out_lo;
    } vcm_code_s;

    // Board pins, after synchronising
    typedef struct packed {
        logic force_zero_n;
        logic write_protect;
        logic path_select_pin;
        logic addr_strap;
        logic [4:0] in_port;
    } vcm_pins_s;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_END,
        ST_ADDR_ACK,
        ST_WDATA,
        ST_WDATA_END,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK,
        ST_RACK_END
    } vcm_state_e;

endpackage : vcm_pkg

`default_nettype wire

// ### verilog/vcm_link_sampler.sv
// Serial-clock domain: samples the data line on each rising serial clock
`default_nettype none

module vcm_link_sampler (
    // Link side
    input wire logic scl_in,
    input wire logic sda_in,
    // Towards the system domain
    output logic bit_toggle_out,
    output logic bit_value_out
);

    // The serial clock only runs inside frames, so no reset can be relied on here
    logic toggle = 1'b0;
    logic value = 1'b1;
    logic next_toggle;
    logic next_value;

    always_comb begin
        next_toggle = ~toggle;
        next_value = sda_in;
    end

    // Value stays put until the next rising edge, long after the toggle is seen
    always_ff @(posedge scl_in) begin
        toggle <= next_toggle;
        value <= next_value;
    end

    assign bit_toggle_out = toggle;
    assign bit_value_out = value;

endmodule : vcm_link_sampler

`default_nettype wire

// ### verilog/vcm_config_mux.sv
// Configuration-code multiplexer with two-wire slave port
`default_nettype none

// Functional notes
// - Override low forces all mux outputs and the auxiliary output to zero.
// - Write-protect high makes serial writes leave stored codes unchanged.
// - Path-select low uses register selection; high passes the input port.
// - Auxiliary latch is transparent with path-select low and code A or B selected, holds otherwise.
// - Held auxiliary value is the one shown when path-select rose.
// - After reset select bit 7 is zero and outputs pass the input port.
// - A written path change takes effect at the next stop condition.
// - Registers: code A at 0, code B at 1, read-only snapshot at 2.
// - Code register: path code bits 7:6, aux bit 4, output bits 5, 3:0.
// - Path code 00 selects code A, 01 code B, 10 the input port.
// - One shared path code, written via either register, reads back in both.
// - Snapshot reads zeros in bits 7:5 and the input port in bits 4:0.
// - Snapshot captures the input port on the first clock after a start.
// - Override and path-select both high drive outputs from the input port.
// - Slave only; never drives the serial clock, master makes every command.
// - Start is data falling with clock high; stop is data rising with clock high.
// - Works at both 100 kbit/s and 400 kbit/s bus rates.
// - Answers only its strap-selected address, never the general call.
// - Reads return code A, code B, snapshot in turn and change nothing.
// - Written byte top bits name the destination, low six bits the contents.
// - Written code reaches outputs only after the 10 ms update, when selected.
module vcm_config_mux #(
    parameter int NV_CYCLES = vcm_pkg::NV_UPDATE_CYCLES
) (
    // System clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Two-wire link
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Board control pins
    input wire logic force_zero_n_in,
    input wire logic write_protect_in,
    input wire logic path_select_pin_in,
    input wire logic addr_strap_in,
    input wire logic [4:0] in_port_in,
    // Multiplexed outputs
    output logic [4:0] y_out,
    output logic aux_bit_out
);

    vcm_pkg::vcm_pins_s pins_raw, pin_meta, pins;
    logic [1:0] scl_sync, sda_sync, tgl_sync;
    logic scl_d, sda_d, tgl_d, bit_toggle, bit_val;
    logic scl_fall, start_ev, stop_ev, bit_ev;

    // the link only samples the clock, never drives it
    vcm_link_sampler u_sampler (
        .scl_in(scl_in),
        .sda_in(sda_in),
        .bit_toggle_out(bit_toggle),
        .bit_value_out(bit_val)
    );

    assign pins_raw = '{force_zero_n: force_zero_n_in, write_protect: write_protect_in,
                        path_select_pin: path_select_pin_in, addr_strap: addr_strap_in,
                        in_port: in_port_in};

    // sync latency suits both rates
    // Two-stage synchronisers for every pin and the bit toggle
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            tgl_sync <= 2'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            tgl_d <= 1'b0;
            pin_meta <= '0;
            pins <= '0;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            tgl_sync <= {tgl_sync[0], bit_toggle};
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
            tgl_d <= tgl_sync[1];
            pin_meta <= pins_raw;
            pins <= pin_meta;
        end
    end

    // start and stop seen only while the clock stays high
    assign start_ev = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
    assign stop_ev = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
    assign scl_fall = scl_d & ~scl_sync[1];
    assign bit_ev = tgl_sync[1] ^ tgl_d;

    // Serial protocol state
    vcm_pkg::vcm_state_e state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shreg, next_shreg;
    logic [7:0] rd_sh, next_rd_sh;
    logic [1:0] rd_idx, next_rd_idx;
    logic [1:0] path_code, next_path_code;
    logic [1:0] active_code, next_active_code;
    logic [4:0] snapshot, next_snapshot;
    logic rw, next_rw, sda_oe, next_sda_oe, snap_arm, next_snap_arm;
    logic path_dirty, next_path_dirty, armed, next_armed, wr_req, next_wr_req;
    logic [6:0] own_addr;
    logic [7:0] load_byte;
    // Stored codes
    vcm_pkg::vcm_code_s code_a, code_b;

    // read data built from live state, reading alters nothing
    function automatic logic [7:0] read_mux(input logic [1:0] idx, input logic [1:0] pc,
                                            input logic [5:0] ca, input logic [5:0] cb,
                                            input logic [4:0] snap);
        logic [7:0] r;
        r = {vcm_pkg::SNAP_PAD, snap};
        // shared path code shows in both code registers
        if (idx == vcm_pkg::REG_CODE_A) begin
            r = {pc, ca};
        end else if (idx == vcm_pkg::REG_CODE_B) begin
            r = {pc, cb};
        end
        return r;
    endfunction : read_mux

    // strap picks one of two addresses; general call never matches
    assign own_addr = pins.addr_strap ? vcm_pkg::ADDR_STRAP_HI : vcm_pkg::ADDR_STRAP_LO;
    // indices 0, 1 and 2; snapshot padded with zeros
    assign load_byte = read_mux(rd_idx, path_code, code_a, code_b, snapshot);

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_rd_sh = rd_sh;
        next_rd_idx = rd_idx;
        next_rw = rw;
        next_sda_oe = sda_oe;
        next_snap_arm = snap_arm;
        next_snapshot = snapshot;
        next_path_code = path_code;
        next_path_dirty = path_dirty;
        next_active_code = active_code;
        next_armed = armed;
        next_wr_req = 1'b0;
        if (stop_ev) begin
            next_state = vcm_pkg::ST_IDLE;
            next_sda_oe = 1'b0;
            next_snap_arm = 1'b0;
            // written path only switches the mux at a stop
            if (path_dirty) begin
                next_active_code = path_code;
                next_armed = 1'b1;
                next_path_dirty = 1'b0;
            end
        end else if (start_ev) begin
            // Repeated start also lands here and restarts addressing
            next_state = vcm_pkg::ST_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b0;
            next_snap_arm = 1'b1;
        end else begin
            // snapshot on the first clock after a start
            if (bit_ev && snap_arm) begin
                next_snapshot = pins.in_port;
                next_snap_arm = 1'b0;
            end
            unique case (state)
                vcm_pkg::ST_IDLE: begin
                    next_sda_oe = 1'b0;
                end
                vcm_pkg::ST_ADDR: begin
                    if (bit_ev) begin
                        next_shreg = {shreg[6:0], bit_val};
                        next_bit_cnt = bit_cnt + 4'h1;
                        if (bit_cnt == vcm_pkg::LAST_BIT) begin
                            next_state = vcm_pkg::ST_ADDR_END;
                        end
                    end
                end
                vcm_pkg::ST_ADDR_END: begin
                    if (scl_fall) begin
                        // foreign addresses are left alone until the next start
                        if (shreg[7:1] == own_addr) begin
                            next_rw = shreg[0];
                            next_sda_oe = 1'b1;
                            next_state = vcm_pkg::ST_ADDR_ACK;
                        end else begin
                            next_state = vcm_pkg::ST_IDLE;
                        end
                    end
                end
                vcm_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_bit_cnt = 4'h0;
                        if (rw) begin
                            // every read begins at code A
                            next_rd_idx = vcm_pkg::REG_CODE_B;
                            next_rd_sh = {read_mux(vcm_pkg::REG_CODE_A, path_code, code_a, code_b, snapshot)};
                            next_sda_oe = ~next_rd_sh[7];
                            next_rd_sh = {next_rd_sh[6:0], 1'b0};
                            next_state = vcm_pkg::ST_RDATA;
                        end else begin
                            next_sda_oe = 1'b0;
                            next_state = vcm_pkg::ST_WDATA;
                        end
                    end
                end
                vcm_pkg::ST_WDATA: begin
                    if (bit_ev) begin
                        next_shreg = {shreg[6:0], bit_val};
                        next_bit_cnt = bit_cnt + 4'h1;
                        if (bit_cnt == vcm_pkg::LAST_BIT) begin
                            next_state = vcm_pkg::ST_WDATA_END;
                        end
                    end
                end
                vcm_pkg::ST_WDATA_END: begin
                    if (scl_fall) begin
                        // Protected writes are still acknowledged, just not stored
                        next_sda_oe = 1'b1;
                        next_state = vcm_pkg::ST_WDATA_ACK;
                        if (!pins.write_protect) begin
                            // one path code whichever register is named
                            next_path_code = shreg[vcm_pkg::PATH_CODE_HI_POS:vcm_pkg::PATH_CODE_LO_POS];
                            next_path_dirty = 1'b1;
                            next_wr_req = 1'b1;
                        end
                    end
                end
                vcm_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        next_sda_oe = 1'b0;
                        next_bit_cnt = 4'h0;
                        next_state = vcm_pkg::ST_WDATA;
                    end
                end
                vcm_pkg::ST_RDATA: begin
                    if (bit_ev) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                    if (scl_fall) begin
                        if (bit_cnt == vcm_pkg::BYTE_DONE) begin
                            next_sda_oe = 1'b0;
                            next_state = vcm_pkg::ST_RACK;
                        end else begin
                            next_sda_oe = ~rd_sh[7];
                            next_rd_sh = {rd_sh[6:0], 1'b0};
                        end
                    end
                end
                vcm_pkg::ST_RACK: begin
                    if (bit_ev) begin
                        next_state = bit_val ? vcm_pkg::ST_IDLE : vcm_pkg::ST_RACK_END;
                    end
                end
                vcm_pkg::ST_RACK_END: begin
                    if (scl_fall) begin
                        // A, B, snapshot, then back round to A
                        next_bit_cnt = 4'h0;
                        next_sda_oe = ~load_byte[7];
                        next_rd_sh = {load_byte[6:0], 1'b0};
                        next_rd_idx = (rd_idx == vcm_pkg::REG_SNAPSHOT) ? vcm_pkg::REG_CODE_A : rd_idx + 2'h1;
                        next_state = vcm_pkg::ST_RDATA;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state <= vcm_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            rd_sh <= 8'h00;
            rd_idx <= vcm_pkg::REG_CODE_A;
            rw <= 1'b0;
            sda_oe <= 1'b0;
            snap_arm <= 1'b0;
            snapshot <= 5'h00;
            // bit 7 clear and no register path armed until a stop
            path_code <= vcm_pkg::PATH_RESET;
            path_dirty <= 1'b0;
            active_code <= vcm_pkg::PATH_RESET;
            armed <= 1'b0;
            wr_req <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            rd_sh <= next_rd_sh;
            rd_idx <= next_rd_idx;
            rw <= next_rw;
            sda_oe <= next_sda_oe;
            snap_arm <= next_snap_arm;
            snapshot <= next_snapshot;
            path_code <= next_path_code;
            path_dirty <= next_path_dirty;
            active_code <= next_active_code;
            armed <= next_armed;
            wr_req <= next_wr_req;
        end
    end

    // Non-volatile update: one pending write, a newer one restarts the timer
    logic nv_busy, next_nv_busy, nv_to_b, next_nv_to_b;
    vcm_pkg::vcm_code_s nv_data, next_nv_data, next_code_a, next_code_b;
    logic [vcm_pkg::NV_CNT_W-1:0] nv_timer, next_nv_timer;
    logic [1:0] wr_dest;

    assign wr_dest = shreg[vcm_pkg::PATH_CODE_HI_POS:vcm_pkg::PATH_CODE_LO_POS];

    always_comb begin
        next_nv_busy = nv_busy;
        next_nv_to_b = nv_to_b;
        next_nv_data = nv_data;
        next_nv_timer = nv_timer;
        next_code_a = code_a;
        next_code_b = code_b;
        // top bits name the destination, low six the contents
        if (wr_req && (wr_dest == vcm_pkg::PATH_CODE_A || wr_dest == vcm_pkg::PATH_CODE_B)) begin
            next_nv_busy = 1'b1;
            next_nv_to_b = (wr_dest == vcm_pkg::PATH_CODE_B);
            next_nv_data = shreg[5:0];
            next_nv_timer = vcm_pkg::NV_CNT_W'(NV_CYCLES - 1);
        end else if (nv_busy) begin
            // new code only visible once the update time is over
            if (nv_timer == '0) begin
                next_nv_busy = 1'b0;
                if (nv_to_b) begin
                    next_code_b = nv_data;
                end else begin
                    next_code_a = nv_data;
                end
            end else begin
                next_nv_timer = nv_timer - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            nv_busy <= 1'b0;
            nv_to_b <= 1'b0;
            nv_data <= vcm_pkg::CODE_RESET;
            nv_timer <= '0;
            code_a <= vcm_pkg::CODE_RESET;
            code_b <= vcm_pkg::CODE_RESET;
        end else begin
            nv_busy <= next_nv_busy;
            nv_to_b <= next_nv_to_b;
            nv_data <= next_nv_data;
            nv_timer <= next_nv_timer;
            code_a <= next_code_a;
            code_b <= next_code_b;
        end
    end

    // Output multiplexer and auxiliary latch
    logic aux_latch, next_aux_latch, next_aux_out, use_code;
    logic [4:0] next_y;
    vcm_pkg::vcm_code_s sel_code;

    // 00 code A, 01 code B, 10 input; an illegal 11 falls back to input
    assign use_code = armed && !pins.path_select_pin &&
                      (active_code == vcm_pkg::PATH_CODE_A || active_code == vcm_pkg::PATH_CODE_B);
    assign sel_code = (active_code == vcm_pkg::PATH_CODE_B) ? code_b : code_a;

    always_comb begin
        next_aux_latch = aux_latch;
        // transparent only with path-select low; holds on its rise
        // input path selected leaves the latch alone
        if (!pins.path_select_pin && use_code) begin
            next_aux_latch = sel_code.aux_bit;
        end
        // path-select high or input code passes the port
        // bit 5 and bits 3:0 make the output code
        next_y = use_code ? {sel_code.out_hi, sel_code.out_lo} : pins.in_port;
        next_aux_out = next_aux_latch;
        if (!pins.force_zero_n) begin
            next_y = 5'h00;
            next_aux_out = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            aux_latch <= 1'b0;
            y_out <= 5'h00;
            aux_bit_out <= 1'b0;
            sda_out <= 1'b0;
            sda_oe_out <= 1'b0;
        end else begin
            aux_latch <= next_aux_latch;
            y_out <= next_y;
            aux_bit_out <= next_aux_out;
            // Open drain: only ever pulls low
            sda_out <= 1'b0;
            sda_oe_out <= sda_oe;
        end
    end

endmodule : vcm_config_mux

`default_nettype wire

// ### verification/vcm_config_mux_assertions.sv
// Port-level checker for the configuration-code multiplexer
`default_nettype none
module vcm_config_mux_assertions #(
    parameter int NV_CYCLES = 20
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Link
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    // Pins and outputs
    input wire logic force_zero_n_in,
    input wire logic write_protect_in,
    input wire logic path_select_pin_in,
    input wire logic addr_strap_in,
    input wire logic [4:0] in_port_in,
    input wire logic [4:0] y_out,
    input wire logic aux_bit_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    chk_zero_forced: assert property (!force_zero_n_in [*5] |-> y_out == 5'h00)
        else $error("y not forced to zero");
    chk_aux_forced: assert property (!force_zero_n_in |-> ##[0:5] !aux_bit_out)
        else $error("aux not forced to zero");
    chk_pass_input: assert property ((force_zero_n_in && path_select_pin_in && $stable(in_port_in)) [*6]
        |-> y_out == in_port_in)
        else $error("y does not follow input port");
    chk_aux_held: assert property ((force_zero_n_in && path_select_pin_in) [*6] |-> $stable(aux_bit_out))
        else $error("aux changed while latched");
    chk_drive_low: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    chk_ack_rise: assert property ($rose(sda_oe_out) |-> !scl_in)
        else $error("data pulled while clock high");
    chk_ack_fall: assert property ($fell(sda_oe_out) |-> !scl_in)
        else $error("data released while clock high");
    chk_reset_quiet: assert property ($fell(rst_in) |-> !sda_oe_out && y_out == 5'h00 && !aux_bit_out)
        else $error("outputs busy after reset");
    cov_ack: cover property ($rose(sda_oe_out));
    cov_latch: cover property (force_zero_n_in && $rose(path_select_pin_in));
    cov_force: cover property (!force_zero_n_in [*5]);
endmodule : vcm_config_mux_assertions
bind vcm_config_mux vcm_config_mux_assertions #(.NV_CYCLES(NV_CYCLES)) vcm_config_mux_assertions_inst (
    .sys_clk_in, .rst_in, .scl_in, .sda_in, .sda_out, .sda_oe_out, .force_zero_n_in, .write_protect_in,
    .path_select_pin_in, .addr_strap_in, .in_port_in, .y_out, .aux_bit_out);
`default_nettype wire

// ### verification/vcm_master_model.sv
// Two-wire bus master model; the clock idles high between frames
`default_nettype none
module vcm_master_model (
    // Link
    output logic scl_out,
    output logic sda_low_out,
    input wire logic sda_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int half_ns = 1250;
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        #(half_ns / 2);
        sda_low_out = !b;
        #(half_ns / 2);
        scl_out = 1'b1;
        #(half_ns / 2);
        r = sda_in;
        #(half_ns / 2);
        scl_out = 1'b0;
    endtask : bit_io
    task automatic frame(input logic stop_c);
        #(half_ns / 2);
        sda_low_out = stop_c;
        #(half_ns / 2);
        scl_out = 1'b1;
        #(half_ns);
        sda_low_out = !stop_c;
        #(half_ns);
        scl_out = stop_c;
    endtask : frame
    task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(a, r);
    endtask : byte_io
endmodule : vcm_master_model
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the configuration-code multiplexer
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic fz_n, wp, psel, strap;
    logic [4:0] in_port;
    logic scl, m_low, oe, sda_o, aux, r, hold;
    logic [4:0] y, snap;
    logic [7:0] q, ca, cb;
    logic [7:0] rb [4];
    logic [15:0] seed = 16'hec12;
    int bad_count = 0;
    int total_checks = 0;
    wire sda = !((oe && !sda_o) || m_low);
    vcm_config_mux #(.NV_CYCLES(20)) vcm_config_mux_inst (.sys_clk_in(clk), .rst_in(rst), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_o), .sda_oe_out(oe), .force_zero_n_in(fz_n), .write_protect_in(wp),
        .path_select_pin_in(psel), .addr_strap_in(strap), .in_port_in(in_port), .y_out(y), .aux_bit_out(aux));
    vcm_master_model vcm_master_model_inst (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda));
    initial begin
        forever #20 clk = !clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [7:0] yv(input logic [7:0] c);
        return {3'h0, c[5], c[3:0]};
    endfunction : yv
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic open(input logic [7:0] a, input logic exp);
        vcm_master_model_inst.frame(1'b0);
        vcm_master_model_inst.byte_io(a, 1'b1, q, r);
        check("address ack", {7'h00, exp}, {7'h00, !r});
    endtask : open
    // Holds the bus open past the update time so only the stop can switch paths
    task automatic send(input logic [7:0] d, input logic [7:0] y_pre);
        open(8'h9c, 1'b1);
        vcm_master_model_inst.byte_io(d, 1'b1, q, r);
        check("data ack", 8'h01, {7'h00, !r});
        cyc(30);
        check("y before stop", y_pre, {3'h0, y});
        vcm_master_model_inst.frame(1'b1);
        cyc(8);
    endtask : send
    task automatic rd(input int n);
        open(8'h9d, 1'b1);
        @(posedge clk);
        snap = in_port;
        in_port <= ~in_port;
        for (int i = 0; i < n; i++) begin
            vcm_master_model_inst.byte_io(8'hff, i == n - 1, rb[i], r);
        end
        vcm_master_model_inst.frame(1'b1);
    endtask : rd
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    initial begin
        #3_000_000;
        bad_count++;
        close_out();
    end
    initial begin
        {fz_n, wp, psel, strap, in_port} <= {4'h9, 5'h00};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        seed = lfsr(seed);
        in_port <= seed[4:0];
        cyc(8);
        check("y after reset", {3'h0, in_port}, {3'h0, y});
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            strap <= i[0];
            cyc(4);
            open({7'h00, 1'b0}, 1'b0);
            vcm_master_model_inst.frame(1'b1);
            open({strap ? 7'h37 : 7'h4e, 1'b0}, 1'b0);
            vcm_master_model_inst.frame(1'b1);
            open({strap ? 7'h4e : 7'h37, 1'b0}, 1'b1);
            vcm_master_model_inst.frame(1'b1);
        end
        $display("test addressing ended");
        seed = lfsr(seed);
        ca = {2'h0, seed[5:0]};
        send(ca, {3'h0, in_port});
        check("y code a", yv(ca), {3'h0, y});
        check("aux code a", {7'h00, ca[4]}, {7'h00, aux});
        seed = lfsr(seed);
        cb = {2'h1, seed[5:0]};
        send(cb, yv(ca));
        check("y code b", yv(cb), {3'h0, y});
        rd(4);
        check("read a", {2'h1, ca[5:0]}, rb[0]);
        check("read b", cb, rb[1]);
        check("read snapshot", {3'h0, snap}, rb[2]);
        check("read wrap", {2'h1, ca[5:0]}, rb[3]);
        check("y after read", yv(cb), {3'h0, y});
        $display("test write and read ended");
        @(posedge clk);
        psel <= 1'b1;
        cyc(8);
        check("y pass", {3'h0, in_port}, {3'h0, y});
        hold = cb[4];
        check("aux at rise", {7'h00, hold}, {7'h00, aux});
        seed = lfsr(seed);
        cb = {2'h1, seed[5], !hold, seed[3:0]};
        send(cb, {3'h0, in_port});
        check("aux latched", {7'h00, hold}, {7'h00, aux});
        @(posedge clk);
        psel <= 1'b0;
        cyc(8);
        check("aux open", {7'h00, cb[4]}, {7'h00, aux});
        check("y new code", yv(cb), {3'h0, y});
        $display("test latch ended");
        vcm_master_model_inst.half_ns = 5000;
        @(posedge clk);
        wp <= 1'b1;
        send({2'h0, ~ca[5:0]}, yv(cb));
        check("y protected", yv(cb), {3'h0, y});
        rd(1);
        check("read protected", {2'h1, ca[5:0]}, rb[0]);
        vcm_master_model_inst.half_ns = 1250;
        wp <= 1'b0;
        send(8'hbf, yv(cb));
        check("y input path", {3'h0, in_port}, {3'h0, y});
        @(posedge clk);
        fz_n <= 1'b0;
        cyc(8);
        check("y forced", 8'h00, {3'h0, y});
        check("aux forced", 8'h00, {7'h00, aux});
        $display("test protect and force ended");
        close_out();
    end
endmodule : tb
`default_nettype wire
